// *** src/fci_init_ctrl.sv ***
// The APB slave port and the placing of the registers were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "fci_defs.svh"

module fci_init_ctrl
  import fci_pkg::*;
#(
  parameter int STEP_UNIT_CYC  = `FCI_MS_CYC,
  parameter int MOTOR_UNIT_CYC = `FCI_MS_CYC,
  parameter int OFF_UNIT_CYC   = `FCI_MS_CYC
) (
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [3:0]  track0,
  output logic             stepOut,
  output logic             dirOut,
  output logic [3:0]       motorOut,
  output logic [1:0]       driveSel,
  output logic             irq,
  output logic [1:0]       dataRate,
  output logic             fifoEnable,
  output logic [3:0]       fifoThreshold,
  output logic             impliedSeekEn,
  output logic             dmaEnable,
  output logic             headSettleEn,
  output logic             openCollector,
  output logic             isoFormat,
  output logic [1:0]       lowPowerMode,
  output logic             burstMode
);

  // mode command parameter layout
  localparam int MF_SETTLE = 0;
  localparam int MF_OC     = 1;
  localparam int MF_ISO    = 2;
  localparam int MF_LP     = 3;
  localparam int MF_STEP   = 5;
  localparam int MF_BURST  = 6;
  localparam int MF_MODE1  = 7;

  localparam fci_regs_t RST_VAL = '{
    state: ST_RESET, digOut: 8'h00, rate: `FCI_RATE_250K, fifoOff: 1'b1, fifoThr: `FCI_FIFOTHR_RST,
    impliedSeek: 1'b0, pretrack: 8'h00, locked: 1'b0, stepRate: 4'h0, motorOffTime: 4'h0,
    motorOnTime: 7'h00, nonDma: 1'b0, modeFlags: 8'h00, byteCnt: 3'h0, cmd: 8'h00, p1: 8'h00,
    p2: 8'h00, p3: 8'h00, res0: 8'h00, res1: 8'h00, resLen: 2'h0, resIdx: 1'b0, pollPend: 4'h0,
    recDone: 1'b0, recSt0: 8'h00, recDrive: 2'h0, cyl: 8'h00, stepCnt: 8'h00, timer: 24'h000000,
    stepOut: 1'b0, motorOut: 4'h0, offTimer: 24'h000000, intStat: 2'h0, intEn: 2'h0,
    prdata: 32'h00000000};

  fci_regs_t r;
  fci_regs_t next_r;

  function automatic logic [2:0] cmdLen(input logic [7:0] op);
    if (op[6:0] == `FCI_CMD_LOCK) return 3'd1;
    unique case (op)
      `FCI_CMD_MODE:      return 3'd2;
      `FCI_CMD_SPECIFY:   return 3'd3;
      `FCI_CMD_RECAL:     return 3'd2;
      `FCI_CMD_SENSE:     return 3'd1;
      `FCI_CMD_CONFIGURE: return 3'd4;
      `FCI_CMD_REVISION:  return 3'd1;
      default:            return 3'd1;
    endcase
  endfunction

  function automatic logic mapped(input logic [7:0] a);
    return a == `FCI_OFS_DOUT || a == `FCI_OFS_MSTAT || a == `FCI_OFS_CFGC || a == `FCI_OFS_DATA ||
           a == `FCI_OFS_INT_STAT || a == `FCI_OFS_INT_CLR || a == `FCI_OFS_INT_EN;
  endfunction

  // motor-on unit per data rate; slower rates stretch it, except 500K in mode 1, which keeps the 1M unit
  function automatic logic [23:0] motorUnit(input logic [1:0] rt, input logic mode1);
    unique case (rt)
      `FCI_RATE_1M:   return 24'(MOTOR_UNIT_CYC);
      `FCI_RATE_500K: return mode1 ? 24'(MOTOR_UNIT_CYC) : 24'(2 * MOTOR_UNIT_CYC);
      default:        return 24'(4 * MOTOR_UNIT_CYC);
    endcase
  endfunction

  // step interval, (16 - rate code) units scaled by data rate
  function automatic logic [23:0] stepTime(input logic [3:0] srt, input logic [1:0] rt);
    logic [23:0] base;
    base = 24'((16 - int'(srt)) * STEP_UNIT_CYC);
    unique case (rt)
      `FCI_RATE_1M:   return base >> 1;
      `FCI_RATE_500K: return base;
      default:        return base << 1;
    endcase
  endfunction

  logic        setupPh;
  logic        accessPh;
  logic [7:0]  mainStat;
  logic [7:0]  wbyte;
  logic [1:0]  drv;

  assign setupPh  = psel & ~penable;
  assign accessPh = psel & penable;
  assign wbyte    = pwdata[7:0];
  assign drv      = r.p1[1:0];

  // idle with no result pending reads exactly 80h
  always_comb begin
    mainStat = 8'h00;
    mainStat[`FCI_MSTAT_RQM_BIT]  = (r.state == ST_IDLE) || (r.state == ST_CMD) || (r.state == ST_RESULT);
    mainStat[`FCI_MSTAT_DIO_BIT]  = (r.state == ST_RESULT);
    mainStat[`FCI_MSTAT_BUSY_BIT] = (r.state != ST_IDLE) && (r.state != ST_RESET);
    if (r.state == ST_MOTOR || r.state == ST_STEP) begin
      mainStat[r.recDrive] = 1'b1;
    end
  end

  always_comb begin
    next_r = r;

    // apb read data captured in setup so it is stable in the access cycle
    if (setupPh && !pwrite) begin
      next_r.prdata = 32'h00000000;
      unique case (paddr)
        `FCI_OFS_DOUT:     next_r.prdata[7:0] = r.digOut;
        `FCI_OFS_MSTAT:    next_r.prdata[7:0] = mainStat;
        `FCI_OFS_CFGC:     next_r.prdata[1:0] = r.rate;
        `FCI_OFS_DATA:     next_r.prdata[7:0] = (r.state == ST_RESULT) ? (r.resIdx ? r.res1 : r.res0) : 8'h00;
        `FCI_OFS_INT_STAT: next_r.prdata[1:0] = r.intStat;
        `FCI_OFS_INT_EN:   next_r.prdata[1:0] = r.intEn;
        default:           next_r.prdata = 32'h00000000;
      endcase
    end

    // clear first so a same-cycle event below wins
    if (accessPh && pwrite) begin
      unique case (paddr)
        `FCI_OFS_DOUT:    next_r.digOut = wbyte;
        `FCI_OFS_CFGC:    next_r.rate = wbyte[1:0];
        `FCI_OFS_INT_CLR: next_r.intStat = r.intStat & ~wbyte[1:0];
        `FCI_OFS_INT_EN:  next_r.intEn = wbyte[1:0];
        `FCI_OFS_DATA: begin
          if (r.state == ST_IDLE || r.state == ST_CMD) begin
            unique case (r.byteCnt)
              3'd0:    next_r.cmd = wbyte;
              3'd1:    next_r.p1 = wbyte;
              3'd2:    next_r.p2 = wbyte;
              default: next_r.p3 = wbyte;
            endcase
            next_r.byteCnt = r.byteCnt + 3'd1;
            if (r.byteCnt + 3'd1 == cmdLen(r.byteCnt == 3'd0 ? wbyte : r.cmd)) begin
              next_r.state = ST_DISPATCH;
            end else begin
              next_r.state = ST_CMD;
            end
          end
        end
        default: ;
      endcase
    end

    // result bytes are popped on the read access edge
    if (accessPh && !pwrite && paddr == `FCI_OFS_DATA && r.state == ST_RESULT) begin
      if (2'(r.resIdx) + 2'd1 >= r.resLen) begin
        next_r.state  = ST_IDLE;
        next_r.resIdx = 1'b0;
      end else begin
        next_r.resIdx = 1'b1;
      end
    end

    unique case (r.state)
      ST_DISPATCH: begin
        next_r.byteCnt = 3'd0;
        next_r.resIdx  = 1'b0;
        next_r.resLen  = 2'd1;
        next_r.res1    = 8'h00;
        next_r.state   = ST_RESULT;
        if (r.cmd[6:0] == `FCI_CMD_LOCK) begin
          next_r.locked = r.cmd[`FCI_LOCK_BIT];
          next_r.res0   = 8'(r.cmd[`FCI_LOCK_BIT]) << `FCI_LOCK_RES_BIT;
        end else begin
          unique case (r.cmd)
            `FCI_CMD_SPECIFY: begin
              next_r.stepRate     = r.p1[7:4];
              next_r.motorOffTime = r.p1[3:0];
              next_r.motorOnTime  = r.p2[7:1];
              next_r.nonDma       = r.p2[0];
              next_r.state        = ST_IDLE;
            end
            `FCI_CMD_CONFIGURE: begin
              next_r.impliedSeek = r.p2[`FCI_CFG_SEEK_BIT];
              next_r.fifoOff     = r.p2[`FCI_CFG_FIFOOFF_BIT];
              next_r.fifoThr     = r.p2[3:0];
              next_r.pretrack    = r.p3;
              next_r.state       = ST_IDLE;
            end
            `FCI_CMD_MODE: begin
              next_r.modeFlags = r.p1;
              next_r.state     = ST_IDLE;
            end
            `FCI_CMD_REVISION: next_r.res0 = `FCI_REV_CODE;
            `FCI_CMD_RECAL: begin
              next_r.recDrive = drv;
              next_r.recDone  = 1'b0;
              next_r.stepCnt  = 8'h00;
              next_r.timer    = 24'(r.motorOnTime) * motorUnit(r.rate, r.modeFlags[MF_MODE1]);
              next_r.state    = ST_MOTOR;
            end
            `FCI_CMD_SENSE: begin
              next_r.resLen = 2'd2;
              if (r.pollPend != 4'h0) begin
                // one poll report per logical drive, lowest first
                for (int i = 3; i >= 0; i--) begin
                  if (r.pollPend[i]) begin
                    next_r.res0 = `FCI_ST0_POLL | 8'(i);
                  end
                end
                next_r.pollPend = r.pollPend & (r.pollPend - 4'h1);
              end else if (r.recDone) begin
                next_r.res0    = r.recSt0;
                next_r.res1    = r.cyl;
                next_r.recDone = 1'b0;
              end else begin
                next_r.res0   = `FCI_ST0_INVALID;
                next_r.resLen = 2'd1;
              end
            end
            default: next_r.res0 = `FCI_ST0_INVALID;
          endcase
        end
      end
      ST_MOTOR: begin
        // motor spin-up before the first step
        if (r.timer != 24'h000000) begin
          next_r.timer = r.timer - 24'h000001;
        end else begin
          next_r.state = ST_STEP;
        end
      end
      ST_STEP: begin
        if (r.timer != 24'h000000) begin
          next_r.timer = r.timer - 24'h000001;
          // pulse ends after its fixed width; the rest of the count is step spacing
          if (r.timer == stepTime(r.stepRate, r.rate) + 24'h000001) begin
            next_r.stepOut = 1'b0;
          end
        end else if (track0[r.recDrive]) begin
          next_r.stepOut = 1'b0;
          next_r.cyl     = 8'h00;
          next_r.recSt0  = `FCI_ST0_SEEKEND | 8'(r.recDrive);
          next_r.recDone = 1'b1;
          next_r.state   = ST_IDLE;
          next_r.intStat[`FCI_INT_RECAL] = 1'b1;
        end else if (r.stepCnt == (r.modeFlags[MF_STEP] ? `FCI_STEPS_LONG : `FCI_STEPS_NORMAL)) begin
          next_r.recSt0  = `FCI_ST0_RECALERR | 8'(r.recDrive);
          next_r.recDone = 1'b1;
          next_r.state   = ST_IDLE;
          next_r.intStat[`FCI_INT_RECAL] = 1'b1;
        end else begin
          next_r.stepOut = 1'b1;
          next_r.stepCnt = r.stepCnt + 8'h01;
          next_r.timer   = stepTime(r.stepRate, r.rate) + 24'(`FCI_STEP_PW_CYC);
        end
      end
      default: ;
    endcase

    // motors start at once but stop only after the motor-off delay
    next_r.motorOut = r.motorOut | r.digOut[7:4];
    if ((r.motorOut & ~r.digOut[7:4]) != 4'h0) begin
      if (r.offTimer == 24'h000001) begin
        next_r.motorOut = r.digOut[7:4];
        next_r.offTimer = 24'h000000;
      end else if (r.offTimer == 24'h000000) begin
        next_r.offTimer = 24'({r.motorOffTime == 4'h0, r.motorOffTime}) * 24'(OFF_UNIT_CYC);
      end else begin
        next_r.offTimer = r.offTimer - 24'h000001;
      end
    end else begin
      next_r.offTimer = 24'h000000;
    end

    // soft reset while the run bit is low; fifo settings survive only if locked
    if (!r.digOut[`FCI_DOUT_RUN_BIT]) begin
      next_r.state        = ST_RESET;
      next_r.byteCnt      = 3'd0;
      next_r.resIdx       = 1'b0;
      next_r.pollPend     = 4'h0;
      next_r.recDone      = 1'b0;
      next_r.stepOut      = 1'b0;
      next_r.rate         = `FCI_RATE_250K;
      next_r.stepRate     = 4'h0;
      next_r.motorOnTime  = 7'h00;
      next_r.motorOffTime = 4'h0;
      next_r.nonDma       = 1'b0;
      if (!r.locked) begin
        next_r.fifoOff     = 1'b1;
        next_r.fifoThr     = `FCI_FIFOTHR_RST;
        next_r.impliedSeek = 1'b0;
        next_r.pretrack    = 8'h00;
      end
    end else if (r.state == ST_RESET) begin
      next_r.state    = ST_IDLE;
      next_r.pollPend = 4'hf;
      next_r.intStat[`FCI_INT_POLL] = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      r <= RST_VAL;
    end else begin
      r <= next_r;
    end
  end

  // zero wait states keep the slave simple
  assign pready        = 1'b1;
  assign pslverr       = accessPh && !mapped(paddr);
  assign prdata        = r.prdata;
  assign irq           = |(r.intStat & r.intEn);
  assign stepOut       = r.stepOut;
  assign dirOut        = 1'b0;
  assign motorOut      = r.motorOut;
  assign driveSel      = r.digOut[1:0];
  assign dataRate      = r.rate;
  assign fifoEnable    = ~r.fifoOff;
  assign fifoThreshold = r.fifoThr;
  assign impliedSeekEn = r.impliedSeek;
  assign dmaEnable     = r.digOut[`FCI_DOUT_DMA_BIT] & ~r.nonDma;
  assign headSettleEn  = r.modeFlags[MF_SETTLE];
  assign openCollector = r.modeFlags[MF_OC];
  assign isoFormat     = r.modeFlags[MF_ISO];
  assign lowPowerMode  = r.modeFlags[MF_LP +: 2];
  assign burstMode     = r.modeFlags[MF_BURST];

endmodule // fci_init_ctrl

`default_nettype wire

// *** src/fci_defs.svh ***
`ifndef FCI_DEFS_SVH
`define FCI_DEFS_SVH

// apb byte offsets
`define FCI_OFS_DOUT       8'h00
`define FCI_OFS_MSTAT      8'h04
`define FCI_OFS_CFGC       8'h08
`define FCI_OFS_DATA       8'h0c
`define FCI_OFS_INT_STAT   8'h10
`define FCI_OFS_INT_CLR    8'h14
`define FCI_OFS_INT_EN     8'h18

// digital output register fields
`define FCI_DOUT_RUN_BIT   2
`define FCI_DOUT_DMA_BIT   3
`define FCI_DOUT_RELEASE   8'h0c

// main status register values
`define FCI_MSTAT_READY    8'h80
`define FCI_MSTAT_RQM_BIT  7
`define FCI_MSTAT_DIO_BIT  6
`define FCI_MSTAT_BUSY_BIT 4

// data rate codes
`define FCI_RATE_500K      2'h0
`define FCI_RATE_300K      2'h1
`define FCI_RATE_250K      2'h2
`define FCI_RATE_1M        2'h3

// command opcodes
`define FCI_CMD_MODE       8'h01
`define FCI_CMD_SPECIFY    8'h03
`define FCI_CMD_RECAL      8'h07
`define FCI_CMD_SENSE      8'h08
`define FCI_CMD_CONFIGURE  8'h13
`define FCI_CMD_LOCK       7'h14
`define FCI_CMD_REVISION   8'h18

// configure parameter byte
`define FCI_CFG_SEEK_BIT   6
`define FCI_CFG_FIFOOFF_BIT 5
// result codes
`define FCI_ST0_INVALID    8'h80
`define FCI_ST0_POLL       8'hc0
`define FCI_ST0_SEEKEND    8'h20
`define FCI_ST0_RECALERR   8'h70
`define FCI_REV_CODE       8'h5a // arbitrary value
`define FCI_LOCK_BIT       7
`define FCI_LOCK_RES_BIT   4
`define FCI_FIFOTHR_RST    4'h0
`define FCI_STEPS_NORMAL   8'd79
`define FCI_STEPS_LONG     8'd255

// interrupt status bits
`define FCI_INT_POLL       0
`define FCI_INT_RECAL      1

// timing
`define FCI_CLK_PERIOD_NS  50
`define FCI_STEP_PW_NS     8000
`define FCI_STEP_PW_CYC    (((`FCI_STEP_PW_NS) + (`FCI_CLK_PERIOD_NS) - 1) / (`FCI_CLK_PERIOD_NS))
`define FCI_MS_NS          1000000
`define FCI_MS_CYC          ((`FCI_MS_NS) / (`FCI_CLK_PERIOD_NS))

`endif

// *** src/fci_pkg.sv ***
package fci_pkg;

  typedef enum logic [2:0] {ST_RESET, ST_IDLE, ST_CMD, ST_DISPATCH, ST_MOTOR, ST_STEP, ST_RESULT} fci_state_t;

  typedef struct packed {
    fci_state_t  state;
    logic [7:0]  digOut;
    logic [1:0]  rate;
    logic        fifoOff;
    logic [3:0]  fifoThr;
    logic        impliedSeek;
    logic [7:0]  pretrack;
    logic        locked;
    logic [3:0]  stepRate;
    logic [3:0]  motorOffTime;
    logic [6:0]  motorOnTime;
    logic        nonDma;
    logic [7:0]  modeFlags;
    logic [2:0]  byteCnt;
    logic [7:0]  cmd;
    logic [7:0]  p1;
    logic [7:0]  p2;
    logic [7:0]  p3;
    logic [7:0]  res0;
    logic [7:0]  res1;
    logic [1:0]  resLen;
    logic        resIdx;
    logic [3:0]  pollPend;
    logic        recDone;
    logic [7:0]  recSt0;
    logic [1:0]  recDrive;
    logic [7:0]  cyl;
    logic [7:0]  stepCnt;
    logic [23:0] timer;
    logic        stepOut;
    logic [3:0]  motorOut;
    logic [23:0] offTimer;
    logic [1:0]  intStat;
    logic [1:0]  intEn;
    logic [31:0] prdata;
  } fci_regs_t;

endpackage

// *** testbench/fci_init_ctrl_properties.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "fci_defs.svh"

module fci_init_ctrl_properties (
  input wire logic        clk,
  input wire logic        nrst,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        stepOut,
  input wire logic        dirOut,
  input wire logic [1:0]  driveSel,
  input wire logic        irq,
  input wire logic [1:0]  dataRate,
  input wire logic        fifoEnable
);
  localparam int PULSE = `FCI_STEP_PW_CYC;
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);

  logic       accs;
  logic       wr;
  logic       rateWr;
  logic [7:0] highCnt;
  assign accs   = psel && penable;
  assign wr     = accs && pwrite;
  assign rateWr = wr && (paddr == `FCI_OFS_CFGC || paddr == `FCI_OFS_DOUT);

  // counts sampled high cycles of the step pulse; repetition would be far too long
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      highCnt <= 8'h00;
    end else begin
      highCnt <= stepOut ? highCnt + 8'h01 : 8'h00;
    end
  end

  sequence sCfgcWrite;
    wr && paddr == `FCI_OFS_CFGC;
  endsequence
  sequence sDoutWrite;
    wr && paddr == `FCI_OFS_DOUT;
  endsequence
  sequence sMaskAll;
    wr && paddr == `FCI_OFS_INT_EN && pwdata[1:0] == 2'h0;
  endsequence

  AST_PREADY: assert property (accs |-> pready) else $error("pready low in access");
  AST_SLVERR: assert property (accs && paddr[1:0] == 2'h0 |-> pslverr == (paddr > `FCI_OFS_INT_EN))
    else $error("pslverr wrong");
  AST_RD_UPPER: assert property (accs && !pwrite |-> prdata[31:8] == 24'h0)
    else $error("read upper bits set");
  AST_RESET_DEFAULTS: assert property (!$past(nrst) |-> dataRate == `FCI_RATE_250K && !fifoEnable)
    else $error("reset defaults wrong");
  AST_RATE_CFGC: assert property (sCfgcWrite |=> dataRate == $past(pwdata[1:0]))
    else $error("rate not loaded");
  AST_RATE_HOLD: assert property ($changed(dataRate) |-> $past(rateWr) || $past(rateWr, 2))
    else $error("rate changed alone");
  AST_STEP_WIDTH: assert property ($fell(stepOut) |-> highCnt == 8'(PULSE))
    else $error("step pulse width wrong");
  AST_DIR: assert property (stepOut |-> !dirOut) else $error("step away from track 0");
  AST_DRIVE_SEL: assert property (sDoutWrite |=> ##1 driveSel == $past(pwdata[1:0], 2))
    else $error("drive select wrong");
  AST_IRQ_MASK: assert property (sMaskAll |=> !irq) else $error("irq while masked");
endmodule // fci_init_ctrl_properties

bind fci_init_ctrl fci_init_ctrl_properties u_fci_init_ctrl_properties (
  .clk(clk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .stepOut(stepOut),
  .dirOut(dirOut), .driveSel(driveSel), .irq(irq), .dataRate(dataRate), .fifoEnable(fifoEnable));

`default_nettype wire

// *** testbench/fci_drive_model.sv ***
`timescale 1ns/1ps
`default_nettype none

module fci_drive_model #(
  parameter int POS0 = 5,
  parameter int POS1 = 160,
  parameter int POS2 = 0,
  parameter int POS3 = 0
) (
  input wire logic       clk,
  input wire logic       nrst,
  input wire logic       stepOut,
  input wire logic       dirOut,
  input wire logic [1:0] driveSel,
  output logic [3:0]     track0
);
  int   pos [4];
  logic stepQ;

  // only the selected drive moves, as on a shared cable
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pos[0] <= POS0;
      pos[1] <= POS1;
      pos[2] <= POS2;
      pos[3] <= POS3;
      stepQ  <= 1'b0;
    end else begin
      stepQ <= stepOut;
      if (stepOut && !stepQ && !dirOut && pos[driveSel] > 0) begin
        pos[driveSel] <= pos[driveSel] - 1;
      end
    end
  end

  always_comb begin
    for (int i = 0; i < 4; i++) begin
      track0[i] = (pos[i] == 0);
    end
  end
endmodule // fci_drive_model

`default_nettype wire

// *** testbench/testbench.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "fci_defs.svh"
`define CHK(nm, ex, got) begin compares++; if ((got) !== (ex)) begin fails++; \
  $display("CHECK FAILED %s expected %h seen %h", nm, (ex), (got)); end end

module testbench;
  logic        clk = 1'b0;
  logic        nrst = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready, pslverr, stepOut, dirOut, irq, fifoEnable, impliedSeekEn, dmaEnable;
  logic        headSettleEn, openCollector, isoFormat, burstMode;
  logic [3:0]  track0, motorOut, fifoThreshold;
  logic [1:0]  driveSel, dataRate, lowPowerMode;
  logic [31:0] rd;
  logic        slv;
  logic [7:0]  m;
  logic [7:0]  modeVal [6] = '{8'h01, 8'h02, 8'h04, 8'h08, 8'h10, 8'h40};
  int          fails = 0;
  int          compares = 0;
  int          cycles = 0;
  int          tFast, tMode1, tSlow;

  always #25 clk = ~clk;

  fci_init_ctrl #(.STEP_UNIT_CYC(4), .MOTOR_UNIT_CYC(4), .OFF_UNIT_CYC(4)) u_fci_init_ctrl (
    .clk(clk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .track0(track0),
    .stepOut(stepOut), .dirOut(dirOut), .motorOut(motorOut), .driveSel(driveSel), .irq(irq),
    .dataRate(dataRate), .fifoEnable(fifoEnable), .fifoThreshold(fifoThreshold),
    .impliedSeekEn(impliedSeekEn), .dmaEnable(dmaEnable), .headSettleEn(headSettleEn),
    .openCollector(openCollector), .isoFormat(isoFormat), .lowPowerMode(lowPowerMode),
    .burstMode(burstMode));

  fci_drive_model u_fci_drive_model (.clk(clk), .nrst(nrst), .stepOut(stepOut), .dirOut(dirOut),
    .driveSel(driveSel), .track0(track0));

  // one extra edge at the end so register updates of the access edge are visible
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    slv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  task automatic statWait(input logic [1:0] want);
    do apb(1'b0, `FCI_OFS_MSTAT, 32'h0); while (rd[7:6] !== want);
  endtask

  task automatic idle();
    do apb(1'b0, `FCI_OFS_MSTAT, 32'h0); while (rd[7:0] !== `FCI_MSTAT_READY);
  endtask

  task automatic wrByte(input logic [7:0] b);
    statWait(2'b10);
    apb(1'b1, `FCI_OFS_DATA, {24'h0, b});
  endtask

  task automatic rdByte(input string nm, input logic [7:0] ex, input logic en);
    statWait(2'b11);
    apb(1'b0, `FCI_OFS_DATA, 32'h0);
    if (en) `CHK(nm, ex, rd[7:0])
  endtask

  task automatic sense(input logic [7:0] st0, input logic cylOk);
    wrByte(`FCI_CMD_SENSE);
    rdByte("sense st0", st0, 1'b1);
    if (st0 !== `FCI_ST0_INVALID) rdByte("sense cyl", 8'h00, cylOk);
  endtask

  task automatic wake();
    apb(1'b1, `FCI_OFS_DOUT, {24'h0, `FCI_DOUT_RELEASE});
    idle();
    `CHK("irq poll", 1'b1, irq)
    for (int d = 0; d < 4; d++) sense(`FCI_ST0_POLL | 8'(d), 1'b1);
    sense(`FCI_ST0_INVALID, 1'b0);
    apb(1'b1, `FCI_OFS_INT_EN, 32'h0);
    `CHK("irq masked", 1'b0, irq)
    apb(1'b1, `FCI_OFS_INT_EN, 32'h3);
    `CHK("irq unmasked", 1'b1, irq)
    apb(1'b1, `FCI_OFS_INT_CLR, 32'h1);
    `CHK("irq cleared", 1'b0, irq)
  endtask

  task automatic recal(input logic [1:0] drv, input logic [7:0] st0);
    apb(1'b1, `FCI_OFS_DOUT, {24'h0, (8'h10 << drv) | `FCI_DOUT_RELEASE | 8'(drv)});
    wrByte(`FCI_CMD_RECAL);
    wrByte({6'h0, drv});
    do apb(1'b0, `FCI_OFS_INT_STAT, 32'h0); while (rd[`FCI_INT_RECAL] !== 1'b1);
    `CHK("irq recal", 1'b1, irq)
    `CHK("motor on", 4'h1 << drv, motorOut)
    apb(1'b1, `FCI_OFS_INT_CLR, 32'h2);
    sense(st0 | 8'(drv), st0 == `FCI_ST0_SEEKEND);
  endtask

  // drive 2 sits at track 0, so the span is the motor-on wait plus a fixed overhead
  task automatic motorSpan(input logic [1:0] rt, input logic [7:0] md, output int t);
    apb(1'b1, `FCI_OFS_CFGC, {30'h0, rt});
    wrByte(`FCI_CMD_MODE);
    wrByte(md);
    wrByte(`FCI_CMD_RECAL);
    wrByte(8'h02);
    t = 0;
    while (irq !== 1'b1) begin
      @(posedge clk);
      t++;
    end
    apb(1'b1, `FCI_OFS_INT_CLR, 32'h2);
    sense(`FCI_ST0_SEEKEND | 8'h02, 1'b1);
  endtask

  task automatic conclude();
    if (fails == 0 && compares > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 90000) begin
      fails++;
      conclude();
    end
  end

  initial begin
    repeat (6) @(posedge clk);
    nrst <= 1'b1;
    apb(1'b0, `FCI_OFS_MSTAT, 32'h0);
    `CHK("status in reset", 8'h00, rd[7:0])
    `CHK("rate reset", `FCI_RATE_250K, dataRate)
    `CHK("fifo reset", 1'b0, fifoEnable)
    apb(1'b1, `FCI_OFS_INT_EN, 32'h3);
    wake();
    for (int r = 0; r < 4; r++) begin
      apb(1'b1, `FCI_OFS_CFGC, 32'(r));
      `CHK("rate", 2'(r), dataRate)
    end
    wrByte(`FCI_CMD_CONFIGURE);
    wrByte(8'h00);
    wrByte(8'h47);
    wrByte(8'h00);
    idle();
    `CHK("fifo on", 1'b1, fifoEnable)
    `CHK("threshold", 4'h7, fifoThreshold)
    `CHK("implied seek", 1'b1, impliedSeekEn)
    wrByte({1'b1, `FCI_CMD_LOCK});
    rdByte("lock on", 8'h10, 1'b1);
    apb(1'b1, `FCI_OFS_DOUT, 32'h0);
    wake();
    `CHK("rate soft reset", `FCI_RATE_250K, dataRate)
    `CHK("threshold locked", 4'h7, fifoThreshold)
    wrByte({1'b0, `FCI_CMD_LOCK});
    rdByte("lock off", 8'h00, 1'b1);
    apb(1'b1, `FCI_OFS_DOUT, 32'h0);
    wake();
    `CHK("fifo unlocked", 1'b0, fifoEnable)
    `CHK("threshold unlocked", `FCI_FIFOTHR_RST, fifoThreshold)
    for (int n = 0; n < 2; n++) begin
      wrByte(`FCI_CMD_SPECIFY);
      wrByte(8'hf1);
      wrByte(8'h02 | 8'(n));
      idle();
      `CHK("dma", n == 0, dmaEnable)
    end
    foreach (modeVal[i]) begin
      m = modeVal[i];
      wrByte(`FCI_CMD_MODE);
      wrByte(m);
      idle();
      `CHK("mode", {m[6], m[4:3], m[2:0]},
        {burstMode, lowPowerMode, isoFormat, openCollector, headSettleEn})
    end
    wrByte(`FCI_CMD_REVISION);
    rdByte("revision", `FCI_REV_CODE, 1'b1);
    apb(1'b0, 8'h1c, 32'h0);
    `CHK("unmapped", 1'b1, slv)
    recal(2'd0, `FCI_ST0_SEEKEND);
    recal(2'd1, `FCI_ST0_RECALERR);
    wrByte(`FCI_CMD_MODE);
    wrByte(8'h20);
    recal(2'd1, `FCI_ST0_SEEKEND);
    motorSpan(`FCI_RATE_1M, 8'h00, tFast);
    motorSpan(`FCI_RATE_500K, 8'h80, tMode1);
    motorSpan(`FCI_RATE_500K, 8'h00, tSlow);
    `CHK("mode1 motor-on", tFast, tMode1)
    // motor-on of 1 unit of 4 cycles is doubled at 500 kb/s outside mode 1
    `CHK("500k motor-on", tFast + 4, tSlow)
    conclude();
  end
endmodule // testbench

`default_nettype wire
